// ### dtm_pkg.sv
package dtm_pkg;

   // ****************************************
   // Register indices (byte address is 4x)
   // ****************************************
   localparam logic [7:0] DTM_IDX_TIMER_CONTROL = 8'h88;
   localparam logic [7:0] DTM_IDX_TIMER_MODE = 8'h89;
   localparam logic [7:0] DTM_IDX_TIMER_A_LOW = 8'h8a;
   localparam logic [7:0] DTM_IDX_TIMER_B_LOW = 8'h8b;
   localparam logic [7:0] DTM_IDX_TIMER_A_HIGH = 8'h8c;
   localparam logic [7:0] DTM_IDX_TIMER_B_HIGH = 8'h8d;

   // ****************************************
   // Reset values
   // ****************************************
   localparam logic [7:0] DTM_TIMER_CONTROL_RST = 8'h00;
   localparam logic [7:0] DTM_TIMER_MODE_RST = 8'h00;
   localparam logic [7:0] DTM_COUNT_RST = 8'h00;

   // ****************************************
   // Timer mode fields, per timer nibble
   // ****************************************
   localparam int DTM_TIMER_STRIDE = 4;
   localparam int DTM_GATE_BIT = 3;
   localparam int DTM_SOURCE_BIT = 2;
   localparam int DTM_MODE_FIELD_HIGH = 1;
   localparam int DTM_MODE_FIELD_LOW = 0;

   // ****************************************
   // Timer control fields
   // ****************************************
   localparam int DTM_RUN_A_BIT = 4;
   localparam int DTM_FLAG_A_BIT = 5;
   localparam int DTM_RUN_B_BIT = 6;
   localparam int DTM_FLAG_B_BIT = 7;
   localparam int DTM_RUN_STRIDE = 2;

   // ****************************************
   // Timing
   // ****************************************
   localparam int DTM_MACHINE_CYCLE_CLKS = 12;
   localparam logic [4:0] DTM_PRESCALE_MAX = 5'h1f;

   typedef enum logic [1:0] {
      DTM_MODE_PRESCALE,
      DTM_MODE_CASCADE,
      DTM_MODE_RELOAD,
      DTM_MODE_SPLIT
   } dtm_mode_t;

endpackage

// ### dtm_dual_timer.sv
`timescale 1ns/1ps
`default_nettype none

module dtm_dual_timer
   import dtm_pkg::*;
#(
   parameter int ADDR_W = 12
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic wbCyc,
   input wire logic wbStb,
   input wire logic wbWe,
   input wire logic [ADDR_W-1:0] wbAdr,
   input wire logic [3:0] wbSel,
   input wire logic [31:0] wbDatW,
   output logic [31:0] wbDatR,
   output logic wbAck,
   input wire logic extIrqPinA,
   input wire logic extIrqPinB,
   input wire logic countPinA,
   input wire logic countPinB,
   output logic overflowFlagA,
   output logic overflowFlagB
);

   // ****************************************
   // State
   // ****************************************
   logic [7:0] timerControl_q, timerControl_d;
   logic [7:0] timerMode_q;
   logic [7:0] timerALowByte_q, timerAHighByte_q;
   logic [7:0] timerBLowByte_q, timerBHighByte_q;
   logic [3:0] cycleCnt_q;
   logic [1:0] sample_q, samplePrev_q;
   logic ack_q;
   logic [31:0] datR_q;

   // ****************************************
   // Bus decode
   // ****************************************
   wire [7:0] regIdx = wbAdr[9:2];
   wire busReq = wbCyc & wbStb;
   wire busWrite = busReq & wbWe & ack_q & wbSel[0];
   wire hitCtrl = regIdx == DTM_IDX_TIMER_CONTROL;
   wire hitMode = regIdx == DTM_IDX_TIMER_MODE;
   wire hitALow = regIdx == DTM_IDX_TIMER_A_LOW;
   wire hitBLow = regIdx == DTM_IDX_TIMER_B_LOW;
   wire hitAHigh = regIdx == DTM_IDX_TIMER_A_HIGH;
   wire hitBHigh = regIdx == DTM_IDX_TIMER_B_HIGH;
   wire upperZero = (ADDR_W <= 10) || (wbAdr >> 10) == '0;
   wire wrCtrl = busWrite & upperZero & hitCtrl;
   wire wrMode = busWrite & upperZero & hitMode;
   wire wrALow = busWrite & upperZero & hitALow;
   wire wrBLow = busWrite & upperZero & hitBLow;
   wire wrAHigh = busWrite & upperZero & hitAHigh;
   wire wrBHigh = busWrite & upperZero & hitBHigh;
   wire [7:0] wrByte = wbDatW[7:0];
   wire [7:0] readByte = !upperZero ? 8'h00 :
      hitCtrl ? timerControl_q :
      hitMode ? timerMode_q :
      hitALow ? timerALowByte_q :
      hitBLow ? timerBLowByte_q :
      hitAHigh ? timerAHighByte_q :
      hitBHigh ? timerBHighByte_q : 8'h00;

   // ****************************************
   // Machine cycle tick
   // ****************************************
   wire tick = cycleCnt_q == 4'(DTM_MACHINE_CYCLE_CLKS - 1);

   // ****************************************
   // Per-timer enable and event source
   // ****************************************
   wire [1:0] irqPin = {extIrqPinB, extIrqPinA};
   wire [1:0] countPin = {countPinB, countPinA};
   logic [1:0] enable, fall, countEvent;
   dtm_mode_t mode [2];

   genvar g;
   generate
      for (g = 0; g < 2; g++) begin : gTimer
         localparam int B = g * DTM_TIMER_STRIDE;
         wire gateBit = timerMode_q[B + DTM_GATE_BIT];
         wire srcBit = timerMode_q[B + DTM_SOURCE_BIT];
         wire runBit = timerControl_q[DTM_RUN_A_BIT + g * DTM_RUN_STRIDE];
         assign mode[g] = dtm_mode_t'({timerMode_q[B + DTM_MODE_FIELD_HIGH],
            timerMode_q[B + DTM_MODE_FIELD_LOW]});
         assign enable[g] = runBit & (~gateBit | irqPin[g]);
         assign fall[g] = tick & samplePrev_q[g] & ~sample_q[g];
         assign countEvent[g] = srcBit ? fall[g] : tick;
      end
   endgenerate

   // ****************************************
   // Count step: {overflow, high, low}
   // ****************************************
   function automatic logic [16:0] dtm_step(input dtm_mode_t m,
      input logic inc, input logic [7:0] hi, input logic [7:0] lo);
      logic [16:0] r;
      r = {1'b0, hi, lo};
      if (inc) begin
         unique case (m)
            DTM_MODE_PRESCALE: begin
               r[4:0] = lo[4:0] + 5'h01;
               if (lo[4:0] == DTM_PRESCALE_MAX) begin
                  r[15:8] = hi + 8'h01;
                  r[16] = hi == 8'hff;
               end
            end
            DTM_MODE_CASCADE: begin
               r[15:0] = {hi, lo} + 16'h0001;
               r[16] = {hi, lo} == 16'hffff;
            end
            DTM_MODE_RELOAD: begin
               r[7:0] = (lo == 8'hff) ? hi : lo + 8'h01;
               r[16] = lo == 8'hff;
            end
            DTM_MODE_SPLIT: begin
               r[7:0] = lo + 8'h01;
               r[16] = lo == 8'hff;
            end
         endcase
      end
      return r;
   endfunction

   wire splitA = mode[0] == DTM_MODE_SPLIT;
   wire runB = timerControl_q[DTM_RUN_B_BIT];
   wire incA = enable[0] & countEvent[0];
   wire incB = enable[1] & countEvent[1] & (mode[1] != DTM_MODE_SPLIT);
   wire incAHigh = splitA & runB & tick;
   wire [16:0] stepA = dtm_step(mode[0], incA, timerAHighByte_q,
      timerALowByte_q);
   wire [16:0] stepB = dtm_step(mode[1], incB, timerBHighByte_q,
      timerBLowByte_q);
   wire [8:0] stepAHigh = {1'b0, timerAHighByte_q} + {8'h00, incAHigh};
   wire [7:0] nextAHigh = splitA ? stepAHigh[7:0] : stepA[15:8];
   wire ovfA = stepA[16];
   wire ovfB = splitA ? (incAHigh & timerAHighByte_q == 8'hff) : stepB[16];

   // Hardware set wins over a software clear in the same cycle
   always_comb begin
      timerControl_d = wrCtrl ? wrByte : timerControl_q;
      timerControl_d[DTM_FLAG_A_BIT] = timerControl_d[DTM_FLAG_A_BIT] | ovfA;
      timerControl_d[DTM_FLAG_B_BIT] = timerControl_d[DTM_FLAG_B_BIT] | ovfB;
   end

   // ****************************************
   // Registers
   // ****************************************
   always_ff @(posedge clk) begin
      if (rst || tick) begin
         cycleCnt_q <= 4'h0;
      end else begin
         cycleCnt_q <= cycleCnt_q + 4'h1;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         sample_q <= 2'h0;
         samplePrev_q <= 2'h0;
      end else if (tick) begin
         sample_q <= countPin;
         samplePrev_q <= sample_q;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         timerControl_q <= DTM_TIMER_CONTROL_RST;
         timerMode_q <= DTM_TIMER_MODE_RST;
      end else begin
         timerControl_q <= timerControl_d;
         timerMode_q <= wrMode ? wrByte : timerMode_q;
      end
   end

   // Software writes to a count byte win over counting
   always_ff @(posedge clk) begin
      if (rst) begin
         timerALowByte_q <= DTM_COUNT_RST;
         timerAHighByte_q <= DTM_COUNT_RST;
         timerBLowByte_q <= DTM_COUNT_RST;
         timerBHighByte_q <= DTM_COUNT_RST;
      end else begin
         timerALowByte_q <= wrALow ? wrByte : stepA[7:0];
         timerAHighByte_q <= wrAHigh ? wrByte : nextAHigh;
         timerBLowByte_q <= wrBLow ? wrByte : stepB[7:0];
         timerBHighByte_q <= wrBHigh ? wrByte : stepB[15:8];
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         ack_q <= 1'b0;
         datR_q <= 32'h0000_0000;
      end else begin
         ack_q <= busReq & ~ack_q;
         datR_q <= (busReq & ~ack_q) ? {24'h000000, readByte} : datR_q;
      end
   end

   assign wbAck = ack_q;
   assign wbDatR = datR_q;
   assign overflowFlagA = timerControl_q[DTM_FLAG_A_BIT];
   assign overflowFlagB = timerControl_q[DTM_FLAG_B_BIT];

   // ****************************************
   // Assertions
   // ****************************************
   wire anyWr = wrALow | wrAHigh | wrBLow | wrBHigh | wrCtrl | wrMode;

   property p_reset_zero;
      @(posedge clk) rst |=> timerMode_q == 8'h00 && timerControl_q == 8'h00;
   endproperty
   a_reset_zero: assert property (p_reset_zero)
      else $error("mode or control not zero after reset");

   property p_tick_period;
      @(posedge clk) disable iff (rst) tick |=> !tick ##10 !tick ##1 tick;
   endproperty
   a_tick_period: assert property (p_tick_period)
      else $error("machine cycle tick not every 12 clocks");

   property p_gate_blocks;
      @(posedge clk) disable iff (rst)
      timerMode_q[DTM_GATE_BIT] && !extIrqPinA && !anyWr
      |=> $stable(timerALowByte_q);
   endproperty
   a_gate_blocks: assert property (p_gate_blocks)
      else $error("timer A counted while gated off");

   property p_free_run;
      @(posedge clk) disable iff (rst)
      !timerMode_q[DTM_GATE_BIT] && !timerMode_q[DTM_SOURCE_BIT]
      && mode[0] == DTM_MODE_CASCADE && timerControl_q[DTM_RUN_A_BIT]
      && tick && !anyWr
      |=> {timerAHighByte_q, timerALowByte_q}
         == $past({timerAHighByte_q, timerALowByte_q}) + 16'h0001;
   endproperty
   a_free_run: assert property (p_free_run)
      else $error("timer A missed a machine cycle");

   property p_counter_src;
      @(posedge clk) disable iff (rst)
      timerMode_q[DTM_SOURCE_BIT] && !fall[0] && !anyWr
      |=> $stable(timerALowByte_q);
   endproperty
   a_counter_src: assert property (p_counter_src)
      else $error("counter advanced without pin edge");

   property p_prescale_carry;
      @(posedge clk) disable iff (rst)
      mode[0] == DTM_MODE_PRESCALE && incA && !anyWr
      && timerALowByte_q[4:0] == 5'h1f
      |=> timerALowByte_q[4:0] == 5'h00
         && timerAHighByte_q == $past(timerAHighByte_q) + 8'h01;
   endproperty
   a_prescale_carry: assert property (p_prescale_carry)
      else $error("prescaler did not carry into high byte");

   property p_reload;
      @(posedge clk) disable iff (rst)
      mode[1] == DTM_MODE_RELOAD && incB && timerBLowByte_q == 8'hff
      && !splitA && !anyWr
      |=> timerBLowByte_q == timerBHighByte_q && overflowFlagB;
   endproperty
   a_reload: assert property (p_reload)
      else $error("low byte not reloaded from high byte");

   property p_split_high;
      @(posedge clk) disable iff (rst)
      splitA && runB && tick && !anyWr
      |=> timerAHighByte_q == $past(timerAHighByte_q) + 8'h01;
   endproperty
   a_split_high: assert property (p_split_high)
      else $error("split high byte not counting on timer B run");

   property p_b_frozen;
      @(posedge clk) disable iff (rst)
      mode[1] == DTM_MODE_SPLIT && !anyWr
      |=> $stable({timerBHighByte_q, timerBLowByte_q});
   endproperty
   a_b_frozen: assert property (p_b_frozen)
      else $error("timer B moved in mode 11");

   property p_run_off;
      @(posedge clk) disable iff (rst)
      !timerControl_q[DTM_RUN_A_BIT] && !splitA && !anyWr
      |=> $stable({timerAHighByte_q, timerALowByte_q});
   endproperty
   a_run_off: assert property (p_run_off)
      else $error("timer A counted with run bit clear");

   property p_fall_detect;
      @(posedge clk) disable iff (rst)
      tick && countPinA ##1 (!tick)[*1] ##10 !tick ##1 (tick && !countPinA)
      ##1 (!tick)[*1] ##10 1'b1 |-> ##1 fall[0];
   endproperty
   a_fall_detect: assert property (p_fall_detect)
      else $error("high-to-low pin transition not detected");

endmodule

`default_nettype wire

// ### dtm_pin_model.sv
`timescale 1ns/1ps
`default_nettype none

module dtm_pin_model (
   input wire logic clk,
   input wire logic pulseA,
   input wire logic pulseB,
   input wire logic gateA,
   input wire logic gateB,
   output logic countPinA,
   output logic countPinB,
   output logic extIrqPinA,
   output logic extIrqPinB
);
   logic [4:0] divQ;

   initial begin
      divQ = 5'h00;
      countPinA = 1'b1;
      countPinB = 1'b1;
      extIrqPinA = 1'b0;
      extIrqPinB = 1'b0;
      // Pulses hold each level for two machine cycles; idle level is high
      forever begin
         @(posedge clk);
         divQ <= (divQ == 5'h17) ? 5'h00 : divQ + 5'h01;
         if (divQ == 5'h17) begin
            countPinA <= pulseA ? ~countPinA : 1'b1;
            countPinB <= pulseB ? ~countPinB : 1'b1;
         end
         extIrqPinA <= gateA;
         extIrqPinB <= gateB;
      end
   end
endmodule

`default_nettype wire

// ### dtm_dual_timer_tb_top.sv
`timescale 1ns/1ps
`default_nettype none

module dtm_dual_timer_tb_top;
   import dtm_pkg::*;
   localparam logic [11:0] CT = 12'h220;
   localparam logic [11:0] MD = 12'h224;
   localparam logic [11:0] AL = 12'h228;
   localparam logic [11:0] BL = 12'h22c;
   localparam logic [11:0] AH = 12'h230;
   localparam logic [11:0] BH = 12'h234;
   logic clk, rst, wbCyc, wbStb, wbWe, wbAck, fA, fB;
   logic [11:0] wbAdr;
   logic [3:0] wbSel;
   logic [31:0] wbDatW, wbDatR;
   logic pA, pB, gA, gB, cpA, cpB, irA, irB;
   logic [7:0] rd, keep;
   int err_total = 0;
   int cmp_count = 0;

   dtm_dual_timer dtm_dual_timer_inst (.clk(clk), .rst(rst),
      .wbCyc(wbCyc), .wbStb(wbStb), .wbWe(wbWe), .wbAdr(wbAdr),
      .wbSel(wbSel), .wbDatW(wbDatW), .wbDatR(wbDatR), .wbAck(wbAck),
      .extIrqPinA(irA), .extIrqPinB(irB), .countPinA(cpA),
      .countPinB(cpB), .overflowFlagA(fA), .overflowFlagB(fB));
   dtm_pin_model dtm_pin_model_inst (.clk(clk), .pulseA(pA),
      .pulseB(pB), .gateA(gA), .gateB(gB), .countPinA(cpA),
      .countPinB(cpB), .extIrqPinA(irA), .extIrqPinB(irB));

   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   // ****************************************
   // Bus and check tasks
   // ****************************************
   task automatic xfer(input logic we, input logic [11:0] a,
                       input logic [7:0] d);
      @(posedge clk);
      wbCyc <= 1'b1;
      wbStb <= 1'b1;
      wbWe <= we;
      wbAdr <= a;
      wbDatW <= {24'h000000, d};
      do begin
         @(posedge clk);
      end while (wbAck !== 1'b1);
      rd = wbDatR[7:0];
      wbCyc <= 1'b0;
      wbStb <= 1'b0;
      wbWe <= 1'b0;
   endtask

   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         err_total++;
         $display("wrong value at %0t: saw %h want %h", $time, seen, exp);
      end
   endtask

   task automatic rdc(input logic [11:0] a, input logic [7:0] e);
      xfer(1'b0, a, 8'h00);
      check(rd, e);
   endtask

   task automatic rdr(input logic [11:0] a, input logic [7:0] lo,
                      input logic [7:0] hi);
      xfer(1'b0, a, 8'h00);
      check({7'h00, (rd >= lo && rd <= hi)}, 8'h01);
   endtask

   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      xfer(1'b1, a, d);
   endtask

   task automatic idle(input int n);
      repeat (n) @(posedge clk);
   endtask

   task automatic test_done;
      $display("mismatches %0d, comparisons %0d", err_total, cmp_count);
      if (err_total == 0 && cmp_count > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   initial begin
      idle(20000);
      err_total++;
      test_done();
   end

   // ****************************************
   // Scenarios
   // ****************************************
   initial begin
      rst = 1'b1;
      wbCyc = 1'b0;
      wbStb = 1'b0;
      wbWe = 1'b0;
      wbAdr = 12'h000;
      wbSel = 4'hf;
      wbDatW = 32'h00000000;
      pA = 1'b0;
      pB = 1'b0;
      gA = 1'b0;
      gB = 1'b0;
      idle(8);
      rst <= 1'b0;
      rdc(CT, 8'h00);
      rdc(MD, 8'h00);
      rdc(12'h420, 8'h00);
      // Cascaded count from fe runs over into the high byte
      wr(MD, 8'h01);
      wr(AL, 8'hfe);
      wr(CT, 8'h10);
      idle(120);
      wr(CT, 8'h00);
      rdr(AL, 8'h07, 8'h0a);
      keep = rd;
      rdc(AH, 8'h01);
      idle(60);
      rdc(AL, keep);
      // Gate pins hold both timers until raised
      wr(MD, 8'h99);
      wr(AL, 8'h00);
      wr(BL, 8'h00);
      wr(CT, 8'h50);
      idle(60);
      rdc(AL, 8'h00);
      rdc(BL, 8'h00);
      gA <= 1'b1;
      gB <= 1'b1;
      idle(60);
      rdr(AL, 8'h03, 8'h06);
      rdr(BL, 8'h03, 8'h06);
      wr(CT, 8'h00);
      gA <= 1'b0;
      gB <= 1'b0;
      // Counter mode ignores the clock and counts pin falls
      wr(MD, 8'h55);
      wr(AL, 8'h00);
      wr(BL, 8'h00);
      wr(CT, 8'h50);
      idle(120);
      rdc(AL, 8'h00);
      pA <= 1'b1;
      pB <= 1'b1;
      idle(480);
      pA <= 1'b0;
      pB <= 1'b0;
      rdr(AL, 8'h08, 8'h0b);
      rdr(BL, 8'h08, 8'h0b);
      wr(CT, 8'h00);
      // Autoreload keeps both low bytes within fd..ff
      wr(MD, 8'h22);
      wr(AH, 8'hfd);
      wr(AL, 8'hfd);
      wr(BH, 8'hfd);
      wr(BL, 8'hfd);
      wr(CT, 8'h50);
      idle(120);
      rdr(AL, 8'hfd, 8'hff);
      rdc(AH, 8'hfd);
      check({7'h00, fA}, 8'h01);
      rdr(BL, 8'hfd, 8'hff);
      check({7'h00, fB}, 8'h01);
      wr(CT, 8'h00);
      // Five-bit prescaler carries into the high byte
      wr(MD, 8'h00);
      wr(AH, 8'h00);
      wr(AL, 8'h1d);
      wr(CT, 8'h10);
      idle(60);
      wr(CT, 8'h00);
      rdc(AH, 8'h01);
      rdr(AL, 8'h00, 8'h06);
      // Split: high byte follows timer B run, timer B frozen
      wr(MD, 8'h33);
      wr(AL, 8'h00);
      wr(AH, 8'hfc);
      wr(BL, 8'h00);
      wr(CT, 8'h40);
      idle(120);
      check({7'h00, fB}, 8'h01);
      wr(CT, 8'h00);
      rdr(AH, 8'h05, 8'h07);
      rdc(AL, 8'h00);
      rdc(BL, 8'h00);
      wr(CT, 8'h10);
      idle(120);
      wr(CT, 8'h00);
      rdr(AL, 8'h09, 8'h0b);
      rdr(AH, 8'h05, 8'h07);
      rdc(BH, 8'hfd);
      // Reset again in mid-run with nonzero mode and control
      wr(CT, 8'h50);
      rst <= 1'b1;
      idle(3);
      rst <= 1'b0;
      rdc(MD, 8'h00);
      rdc(CT, 8'h00);
      test_done();
   end
endmodule

`default_nettype wire
